// ---- dspmc_pkg.sv ----
package dspmc_pkg;
  // Instruction register
  localparam int          IR_W         = 4;
  localparam logic [3:0]  INS_EXTEST   = 4'h0;
  localparam logic [3:0]  INS_SAMPLE   = 4'h1;
  localparam logic [3:0]  INS_IDCODE   = 4'he;
  localparam logic [3:0]  INS_SCAN_N   = 4'h2;
  localparam logic [3:0]  INS_INTEST   = 4'hc;
  localparam logic [3:0]  INS_BYPASS   = 4'hf;
  localparam logic [3:0]  IR_CAPTURE   = 4'h1;
  // Chain select register
  localparam int          SCAN_N_W     = 4;
  localparam logic [3:0]  CHAIN_CORE   = 4'h1;
  localparam logic [3:0]  CHAIN_ICE    = 4'h2;
  localparam logic [3:0]  CHAIN_RESET  = 4'h2;
  // Identification value, arbitrary
  localparam logic [31:0] ID_VALUE     = 32'h1234_5679;
  // Debug reset pin: a 2.5 period hold is only sure to give two low samples
  localparam real         DBG_RST_PERIODS = 2.5;
  localparam int          DBG_RST_CYCLES  = 2;
  localparam int          POR_CYCLES      = 4;

  typedef enum logic [3:0] {
    DSPMC_RESET   = 4'h0, DSPMC_IDLE    = 4'h1, DSPMC_SEL_DR  = 4'h2,
    DSPMC_CAP_DR  = 4'h3, DSPMC_SH_DR   = 4'h4, DSPMC_EX1_DR  = 4'h5,
    DSPMC_PAU_DR  = 4'h6, DSPMC_EX2_DR  = 4'h7, DSPMC_UPD_DR  = 4'h8,
    DSPMC_SEL_IR  = 4'h9, DSPMC_CAP_IR  = 4'ha, DSPMC_SH_IR   = 4'hb,
    DSPMC_EX1_IR  = 4'hc, DSPMC_PAU_IR  = 4'hd, DSPMC_EX2_IR  = 4'he,
    DSPMC_UPD_IR  = 4'hf
  } dspmc_tap_t;
endpackage : dspmc_pkg

// ---- dspmc_tap_fsm.sv ----
`timescale 1ns/1ps
module dspmc_tap_fsm (
  input  wire logic            tck_i,          // Scan clock
  input  wire logic            trst_i,         // Async debug reset, high
  input  wire logic            tms_i,          // Mode select
  output dspmc_pkg::dspmc_tap_t state_o        // Current state
);
  dspmc_pkg::dspmc_tap_t state_q;
  dspmc_pkg::dspmc_tap_t state_d;

  // Standard sixteen-state walk
  always_comb begin
    case (state_q)
      dspmc_pkg::DSPMC_RESET:  state_d = tms_i ? dspmc_pkg::DSPMC_RESET  : dspmc_pkg::DSPMC_IDLE;
      dspmc_pkg::DSPMC_IDLE:   state_d = tms_i ? dspmc_pkg::DSPMC_SEL_DR : dspmc_pkg::DSPMC_IDLE;
      dspmc_pkg::DSPMC_SEL_DR: state_d = tms_i ? dspmc_pkg::DSPMC_SEL_IR : dspmc_pkg::DSPMC_CAP_DR;
      dspmc_pkg::DSPMC_CAP_DR: state_d = tms_i ? dspmc_pkg::DSPMC_EX1_DR : dspmc_pkg::DSPMC_SH_DR;
      dspmc_pkg::DSPMC_SH_DR:  state_d = tms_i ? dspmc_pkg::DSPMC_EX1_DR : dspmc_pkg::DSPMC_SH_DR;
      dspmc_pkg::DSPMC_EX1_DR: state_d = tms_i ? dspmc_pkg::DSPMC_UPD_DR : dspmc_pkg::DSPMC_PAU_DR;
      dspmc_pkg::DSPMC_PAU_DR: state_d = tms_i ? dspmc_pkg::DSPMC_EX2_DR : dspmc_pkg::DSPMC_PAU_DR;
      dspmc_pkg::DSPMC_EX2_DR: state_d = tms_i ? dspmc_pkg::DSPMC_UPD_DR : dspmc_pkg::DSPMC_SH_DR;
      dspmc_pkg::DSPMC_UPD_DR: state_d = tms_i ? dspmc_pkg::DSPMC_SEL_DR : dspmc_pkg::DSPMC_IDLE;
      dspmc_pkg::DSPMC_SEL_IR: state_d = tms_i ? dspmc_pkg::DSPMC_RESET  : dspmc_pkg::DSPMC_CAP_IR;
      dspmc_pkg::DSPMC_CAP_IR: state_d = tms_i ? dspmc_pkg::DSPMC_EX1_IR : dspmc_pkg::DSPMC_SH_IR;
      dspmc_pkg::DSPMC_SH_IR:  state_d = tms_i ? dspmc_pkg::DSPMC_EX1_IR : dspmc_pkg::DSPMC_SH_IR;
      dspmc_pkg::DSPMC_EX1_IR: state_d = tms_i ? dspmc_pkg::DSPMC_UPD_IR : dspmc_pkg::DSPMC_PAU_IR;
      dspmc_pkg::DSPMC_PAU_IR: state_d = tms_i ? dspmc_pkg::DSPMC_EX2_IR : dspmc_pkg::DSPMC_PAU_IR;
      dspmc_pkg::DSPMC_EX2_IR: state_d = tms_i ? dspmc_pkg::DSPMC_UPD_IR : dspmc_pkg::DSPMC_SH_IR;
      dspmc_pkg::DSPMC_UPD_IR: state_d = tms_i ? dspmc_pkg::DSPMC_SEL_DR : dspmc_pkg::DSPMC_IDLE;
      default:                 state_d = dspmc_pkg::DSPMC_RESET;
    endcase
  end

  // Rising-edge update; the async reset returns to the reset state
  always_ff @(posedge tck_i or posedge trst_i) begin
    if (trst_i) begin
      state_q <= dspmc_pkg::DSPMC_RESET;
    end else begin
      state_q <= state_d;
    end
  end

  assign state_o = state_q;
endmodule : dspmc_tap_fsm

// ---- dspmc_scan_port.sv ----
`timescale 1ns/1ps
// Functional notes
// - Scan select low routes the scan port to emulation debug logic.
// - Scan select high routes the scan port to boundary-scan logic.
// - Boundary-scan mode implements SAMPLE, EXTEST and BYPASS instructions.
// - Mode is latched at chip reset only; changes need a new reset.
// - State machine advances on the TMS level sampled.
// - TDI shifts into the selected scan register.
// - Selected register shifts out on TDO for daisy chaining.
// - Debug logic reset asserts automatically at power-on.
// - Device drives returned scan clock so a probe can pace TCK.
// - Returned scan clock runs only in emulation debug mode.
// - Debug state lets the scan port insert instructions into the core.
// - Exported register data shifts out without disturbing the system.
// - Two internal scan chains, both controlled through the scan port.
// - Comm channel tx and rx activity raise debug serial unit interrupts.
module dspmc_scan_port #(
  parameter int BSR_LEN   = 484,                 // Boundary register length
  parameter int CORE_LEN  = 33,                  // Instruction insertion chain
  parameter int ICE_LEN   = 38                   // Emulation logic chain
) (
  input  wire logic                ref_clk_i,              // Master clock
  input  wire logic                reset_i,                // Sync reset, high
  input  wire logic                tck_i,                  // Scan clock
  input  wire logic                tms_i,                  // Mode select
  input  wire logic                tdi_i,                  // Serial data in
  output logic                     tdo_o,                  // Serial data out
  output logic                     tdo_oe_o,               // TDO drive enable
  input  wire logic                debug_logic_reset_n_i,  // Debug reset pin in
  output logic                     debug_logic_reset_n_o,  // Debug reset pin out
  output logic                     debug_logic_reset_n_oe_o, // Debug reset drive
  output logic                     returned_scan_clock_o,  // Returned clock
  input  wire logic                scan_mode_select_pin_i, // 1 boundary, 0 debug
  input  wire logic                factory_test_select_pin_i, // Must be low
  output logic                     test_mode_reserved_o,   // Reserved test seen
  output logic                     boundary_mode_o,        // Latched mode
  input  wire logic [BSR_LEN-1:0]  pin_sample_i,           // Pad levels
  output logic [BSR_LEN-1:0]       pin_drive_o,            // Forced pad values
  output logic                     extest_active_o,        // Pads under scan
  input  wire logic [CORE_LEN-1:0] core_capture_i,         // Core chain capture
  output logic [CORE_LEN-1:0]      core_insn_o,            // Inserted instruction
  output logic                     core_insn_valid_o,      // Insert pulse
  input  wire logic                core_in_debug_i,        // Core halted
  input  wire logic [ICE_LEN-1:0]  ice_capture_i,          // Ice chain capture
  output logic [ICE_LEN-1:0]       ice_update_o,           // Ice chain update
  output logic                     ice_update_valid_o,     // Ice update pulse
  input  wire logic                comm_channel_tx_activity_i, // Channel tx
  input  wire logic                comm_channel_rx_activity_i, // Channel rx
  output logic                     comm_tx_irq_o,          // Tx interrupt
  output logic                     comm_rx_irq_o           // Rx interrupt
);
  // ---------------- master clock domain
  logic [1:0] dtrst_sync_q;
  logic [1:0] sel_sync_q;
  logic [1:0] tst_sync_q;
  logic [1:0] tck_sync_q;
  logic [2:0] por_cnt_q;
  logic [1:0] pin_low_cnt_q;
  logic       dbg_rst_q;
  logic       mode_q;
  logic       mode_taken_q;
  logic       returned_scan_clock_q;
  logic [1:0] txact_q;
  logic [1:0] rxact_q;

  // Pin synchronisers; first stages feed only second stages
  always_ff @(posedge ref_clk_i) begin
    dtrst_sync_q <= {dtrst_sync_q[0], debug_logic_reset_n_i};
    sel_sync_q   <= {sel_sync_q[0], scan_mode_select_pin_i};
    tst_sync_q   <= {tst_sync_q[0], factory_test_select_pin_i};
    tck_sync_q   <= {tck_sync_q[0], tck_i};
    txact_q      <= {txact_q[0], comm_channel_tx_activity_i};
    rxact_q      <= {rxact_q[0], comm_channel_rx_activity_i};
  end

  // Reserved level flagged, no other effect
  assign test_mode_reserved_o = tst_sync_q[1];

  // Mode caught once after chip reset release, ignored until next reset
  always_ff @(posedge ref_clk_i) begin
    if (reset_i) begin
      mode_taken_q <= 1'b0;
      mode_q       <= 1'b0;
    end else if (!mode_taken_q) begin
      mode_taken_q <= 1'b1;
      mode_q       <= sel_sync_q[1];
    end
  end
  assign boundary_mode_o = mode_q;

  // Power-on stretch, then pin seen low on two synchronised samples resets debug
  always_ff @(posedge ref_clk_i) begin
    if (reset_i) begin
      por_cnt_q     <= 3'h0;
      pin_low_cnt_q <= 2'h0;
      dbg_rst_q     <= 1'b1;
    end else begin
      if (dtrst_sync_q[1]) begin
        pin_low_cnt_q <= 2'h0;
      end else if (pin_low_cnt_q != 2'(dspmc_pkg::DBG_RST_CYCLES)) begin
        pin_low_cnt_q <= pin_low_cnt_q + 2'h1;
      end
      if (por_cnt_q != 3'(dspmc_pkg::POR_CYCLES)) begin
        por_cnt_q <= por_cnt_q + 3'h1;
      end
      dbg_rst_q <= (por_cnt_q != 3'(dspmc_pkg::POR_CYCLES)) ||
                   (pin_low_cnt_q == 2'(dspmc_pkg::DBG_RST_CYCLES));
    end
  end
  // Open-drain style output: drive low during power-on assertion only
  assign debug_logic_reset_n_o    = 1'b0;
  assign debug_logic_reset_n_oe_o = (por_cnt_q != 3'(dspmc_pkg::POR_CYCLES));

  // Returned clock: resynchronised TCK, which bounds the pace to the core
  // Held low until the mode is latched, so no pulse leaks into boundary mode
  always_ff @(posedge ref_clk_i) begin
    if (reset_i) begin
      returned_scan_clock_q <= 1'b0;
    end else begin
      returned_scan_clock_q <= (mode_q || !mode_taken_q) ? 1'b0 : tck_sync_q[1];
    end
  end
  assign returned_scan_clock_o = returned_scan_clock_q;

  // Channel activity levels passed on as interrupt requests
  always_ff @(posedge ref_clk_i) begin
    if (reset_i) begin
      comm_tx_irq_o <= 1'b0;
      comm_rx_irq_o <= 1'b0;
    end else begin
      comm_tx_irq_o <= txact_q[1];
      comm_rx_irq_o <= rxact_q[1];
    end
  end

  // ---------------- scan clock domain
  logic [1:0]               trst_tck_q;
  logic                     mode_meta_q;
  logic [1:0]               halt_sync_q;
  logic                     mode_tck_q;
  dspmc_pkg::dspmc_tap_t    tap_state;
  logic [3:0]               ir_sh_q;
  logic [3:0]               ir_q;
  logic                     byp_q;
  logic [31:0]              id_q;
  logic [3:0]               chsel_sh_q;
  logic [3:0]               chsel_q;
  logic [BSR_LEN-1:0]       bsr_q;
  logic [BSR_LEN-1:0]       bsr_upd_q;
  logic [CORE_LEN-1:0]      core_q;
  logic [ICE_LEN-1:0]       ice_q;
  logic                     sel_out;
  logic                     tdo_q;
  logic                     tdo_en_q;
  logic                     trst_tck;

  // Debug reset into scan domain: asserted async, released by scan clock
  always_ff @(posedge tck_i or posedge dbg_rst_q) begin
    if (dbg_rst_q) begin
      trst_tck_q <= 2'b11;
    end else begin
      trst_tck_q <= {trst_tck_q[0], 1'b0};
    end
  end
  assign trst_tck = trst_tck_q[1];

  // Static mode level carried over with two flops
  always_ff @(posedge tck_i) begin
    mode_meta_q <= mode_q;
    mode_tck_q  <= mode_meta_q;
  end

  // Core halt level comes from the master domain, two flops before use
  always_ff @(posedge tck_i) begin
    halt_sync_q <= {halt_sync_q[0], core_in_debug_i};
  end

  dspmc_tap_fsm u_fsm (
    .tck_i   (tck_i),
    .trst_i  (trst_tck),
    .tms_i   (tms_i),
    .state_o (tap_state)
  );

  function automatic logic is_ins(input logic [3:0] ir, input logic [3:0] code);
    is_ins = (ir == code);
  endfunction : is_ins

  // Instruction register
  always_ff @(posedge tck_i or posedge trst_tck) begin
    if (trst_tck) begin
      ir_sh_q <= dspmc_pkg::INS_IDCODE;
      ir_q    <= dspmc_pkg::INS_IDCODE;
    end else begin
      case (tap_state)
        dspmc_pkg::DSPMC_RESET:  ir_q    <= dspmc_pkg::INS_IDCODE;
        dspmc_pkg::DSPMC_CAP_IR: ir_sh_q <= dspmc_pkg::IR_CAPTURE;
        dspmc_pkg::DSPMC_SH_IR:  ir_sh_q <= {tdi_i, ir_sh_q[3:1]};
        dspmc_pkg::DSPMC_UPD_IR: ir_q    <= ir_sh_q;
        default: ;
      endcase
    end
  end

  // Data registers; debug chains only in debug mode, pads only in scan mode
  always_ff @(posedge tck_i) begin
    if (tap_state == dspmc_pkg::DSPMC_CAP_DR) begin
      byp_q <= 1'b0;
      id_q  <= dspmc_pkg::ID_VALUE;
      chsel_sh_q <= dspmc_pkg::CHAIN_RESET;
      if (mode_tck_q && (is_ins(ir_q, dspmc_pkg::INS_SAMPLE) ||
                         is_ins(ir_q, dspmc_pkg::INS_EXTEST))) begin
        bsr_q <= pin_sample_i;
      end
      if (!mode_tck_q) begin
        core_q <= core_capture_i;
        ice_q  <= ice_capture_i;
      end
    end else if (tap_state == dspmc_pkg::DSPMC_SH_DR) begin
      byp_q      <= tdi_i;
      id_q       <= {tdi_i, id_q[31:1]};
      chsel_sh_q <= {tdi_i, chsel_sh_q[3:1]};
      bsr_q      <= {tdi_i, bsr_q[BSR_LEN-1:1]};
      core_q     <= {tdi_i, core_q[CORE_LEN-1:1]};
      ice_q      <= {tdi_i, ice_q[ICE_LEN-1:1]};
    end
  end

  // Update stage: chain select, pad drive, core insertion
  always_ff @(posedge tck_i or posedge trst_tck) begin
    if (trst_tck) begin
      chsel_q   <= 4'h0;
      bsr_upd_q <= '0;
      core_insn_valid_o  <= 1'b0;
      ice_update_valid_o <= 1'b0;
      core_insn_o  <= '0;
      ice_update_o <= '0;
    end else begin
      core_insn_valid_o  <= 1'b0;
      ice_update_valid_o <= 1'b0;
      if (tap_state == dspmc_pkg::DSPMC_UPD_DR) begin
        if (!mode_tck_q && is_ins(ir_q, dspmc_pkg::INS_SCAN_N)) begin
          chsel_q <= chsel_sh_q;
        end
        if (mode_tck_q && is_ins(ir_q, dspmc_pkg::INS_EXTEST)) begin
          bsr_upd_q <= bsr_q;
        end
        if (!mode_tck_q && is_ins(ir_q, dspmc_pkg::INS_INTEST)) begin
          // A running core would execute a stray word, so insert only when halted
          if (chsel_q == dspmc_pkg::CHAIN_CORE && halt_sync_q[1]) begin
            core_insn_o       <= core_q;
            core_insn_valid_o <= 1'b1;
          end
          if (chsel_q == dspmc_pkg::CHAIN_ICE) begin
            ice_update_o       <= ice_q;
            ice_update_valid_o <= 1'b1;
          end
        end
      end
    end
  end
  assign pin_drive_o     = bsr_upd_q;
  assign extest_active_o = mode_tck_q && is_ins(ir_q, dspmc_pkg::INS_EXTEST);

  // Serial output select; unknown instructions act as bypass
  always_comb begin
    sel_out = byp_q;
    if (tap_state == dspmc_pkg::DSPMC_SH_IR) begin
      sel_out = ir_sh_q[0];
    end else if (is_ins(ir_q, dspmc_pkg::INS_IDCODE)) begin
      sel_out = id_q[0];
    end else if (mode_tck_q) begin
      if (is_ins(ir_q, dspmc_pkg::INS_SAMPLE) || is_ins(ir_q, dspmc_pkg::INS_EXTEST)) begin
        sel_out = bsr_q[0];
      end
    end else if (is_ins(ir_q, dspmc_pkg::INS_SCAN_N)) begin
      sel_out = chsel_sh_q[0];
    end else if (is_ins(ir_q, dspmc_pkg::INS_INTEST)) begin
      sel_out = (chsel_q == dspmc_pkg::CHAIN_CORE) ? core_q[0] :
                (chsel_q == dspmc_pkg::CHAIN_ICE)  ? ice_q[0]  : byp_q;
    end
  end

  // Falling-edge output, so the next chip samples a settled value
  always_ff @(negedge tck_i or posedge trst_tck) begin
    if (trst_tck) begin
      tdo_q    <= 1'b0;
      tdo_en_q <= 1'b0;
    end else begin
      tdo_q    <= sel_out;
      tdo_en_q <= (tap_state == dspmc_pkg::DSPMC_SH_DR) ||
                  (tap_state == dspmc_pkg::DSPMC_SH_IR);
    end
  end
  assign tdo_o    = tdo_q;
  assign tdo_oe_o = tdo_en_q;
endmodule : dspmc_scan_port

// ---- dspmc_scan_port_sva.sv ----
`timescale 1ns/1ps
module dspmc_scan_port_sva (
  input wire logic ref_clk_i,                  // Master clock
  input wire logic reset_i,                    // Chip reset
  input wire logic tck_i,                      // Scan clock
  input wire logic tdo_o,                      // Serial out
  input wire logic tdo_oe_o,                   // Serial out enable
  input wire logic returned_scan_clock_o,      // Returned clock
  input wire logic debug_logic_reset_n_oe_o,   // Debug reset drive
  input wire logic factory_test_select_pin_i,  // Test pin
  input wire logic test_mode_reserved_o,       // Test pin seen
  input wire logic boundary_mode_o,            // Latched mode
  input wire logic extest_active_o,            // Pads under scan
  input wire logic core_insn_valid_o,          // Insert pulse
  input wire logic ice_update_valid_o,         // Ice pulse
  input wire logic comm_channel_tx_activity_i, // Channel tx
  input wire logic comm_channel_rx_activity_i, // Channel rx
  input wire logic comm_tx_irq_o,              // Tx interrupt
  input wire logic comm_rx_irq_o               // Rx interrupt
);
  logic [3:0] since_q;  // Edges since reset

  // Saturating count keeps history checks clear of reset values
  always_ff @(posedge ref_clk_i) begin
    if (reset_i) since_q <= 4'h0;
    else if (since_q != 4'hf) since_q <= since_q + 4'h1;
  end

  default clocking @(posedge ref_clk_i); endclocking
  default disable iff (reset_i);

  returned_scan_clock_boundary_a: assert property (boundary_mode_o |-> !returned_scan_clock_o)
    else $error("returned clock runs in boundary mode");
  returned_scan_clock_follow_a: assert property (
    !boundary_mode_o && since_q > 4'h5 |-> returned_scan_clock_o == $past(tck_i, 3))
    else $error("returned clock does not track scan clock");
  mode_hold_a: assert property (since_q > 4'h3 |-> $stable(boundary_mode_o))
    else $error("mode changed without chip reset");
  irq_tx_a: assert property (
    since_q > 4'h3 |-> comm_tx_irq_o == $past(comm_channel_tx_activity_i, 3))
    else $error("tx interrupt does not follow activity");
  irq_rx_a: assert property (
    since_q > 4'h3 |-> comm_rx_irq_o == $past(comm_channel_rx_activity_i, 3))
    else $error("rx interrupt does not follow activity");
  test_pin_a: assert property (
    since_q > 4'h3 |-> test_mode_reserved_o == $past(factory_test_select_pin_i, 2))
    else $error("reserved test flag wrong");
  por_stretch_a: assert property (
    $fell(reset_i) |-> debug_logic_reset_n_oe_o ##[1:6] !debug_logic_reset_n_oe_o)
    else $error("debug reset stretch wrong");
  tdo_edge_a: assert property (
    since_q > 4'h7 && tck_i && $past(tck_i) |-> $stable(tdo_o) && $stable(tdo_oe_o))
    else $error("serial out moved while scan clock high");
  chain_mode_a: assert property (
    boundary_mode_o |-> !core_insn_valid_o && !ice_update_valid_o)
    else $error("debug chain updated in boundary mode");
  extest_mode_a: assert property (extest_active_o |-> boundary_mode_o)
    else $error("pads driven outside boundary mode");

  cover property (core_insn_valid_o);
  cover property (ice_update_valid_o);
  cover property (extest_active_o);
  cover property (tdo_oe_o);
endmodule : dspmc_scan_port_sva

bind dspmc_scan_port dspmc_scan_port_sva u_dspmc_scan_port_sva (
  .ref_clk_i, .reset_i, .tck_i, .tdo_o, .tdo_oe_o, .returned_scan_clock_o,
  .debug_logic_reset_n_oe_o,
  .factory_test_select_pin_i, .test_mode_reserved_o, .boundary_mode_o, .extest_active_o,
  .core_insn_valid_o, .ice_update_valid_o, .comm_channel_tx_activity_i,
  .comm_channel_rx_activity_i, .comm_tx_irq_o, .comm_rx_irq_o);

// ---- dspmc_probe.sv ----
`timescale 1ns/1ps
module dspmc_probe (
  input  wire logic lnk_clk_i, // Link clock
  input  wire logic tdo_i,     // Serial from device
  output logic      tck_o,     // Scan clock
  output logic      tms_o,     // Mode select
  output logic      tdi_o      // Serial to device
);
  // Idle levels at time zero
  initial begin
    tck_o = 1'b0;
    tms_o = 1'b1;
    tdi_o = 1'b0;
  end

  // Two link periods per scan clock keep it under a sixth of master rate
  task automatic tick(input logic m, input logic d, output logic o);
    @(posedge lnk_clk_i);
    tck_o <= 1'b0;
    tms_o <= m;
    tdi_o <= d;
    @(posedge lnk_clk_i);
    o = tdo_i;
    tck_o <= 1'b1;
  endtask : tick

  // Clock stops low, data line no longer holds its value
  task automatic park();
    @(posedge lnk_clk_i);
    tck_o <= 1'b0;
    tdi_o <= ~tdi_o;
  endtask : park

  task automatic tap_reset();
    logic x;
    repeat (5) tick(1'b1, ~tdi_o, x);
    tick(1'b0, ~tdi_o, x);
    park();
  endtask : tap_reset

  task automatic idle(input int k);
    logic x;
    repeat (k) tick(1'b0, ~tdi_o, x);
    park();
  endtask : idle

  // From run-idle through one IR or DR shift and back, LSB first
  task automatic scan(input logic ir, input logic [63:0] din, input int n,
                      output logic [63:0] dout);
    logic x;
    dout = '0;
    tick(1'b1, ~tdi_o, x);
    if (ir) tick(1'b1, ~tdi_o, x);
    tick(1'b0, ~tdi_o, x);
    tick(1'b0, ~tdi_o, x);
    for (int i = 0; i < n; i++) begin
      tick(i == n - 1, din[i], x);
      dout[i] = x;
    end
    tick(1'b1, ~tdi_o, x);
    tick(1'b0, ~tdi_o, x);
    park();
  endtask : scan
endmodule : dspmc_probe

// ---- test_debug_scan_port_mode_control.sv ----
`timescale 1ns/1ps
module test_debug_scan_port_mode_control;
  localparam int BSR = 16;
  logic ref_clk_i, lnk_clk, reset_i, dbg_rst_n, mode_pin, tx_act, rx_act;
  logic tck, tms, tdi, tdo, bmode, ext, halted;
  logic [BSR-1:0] pins, drive;
  logic [32:0]    core_cap, core_insn;
  logic [37:0]    ice_cap, ice_upd;
  logic [63:0]    din, dout, cap;
  int             bad_count, num_checks, n;

  // Master and link clocks, 2 ns phase gap; their edges still meet, first at 50 ns
  initial begin
    ref_clk_i = 1'b0;
    forever #5 ref_clk_i = ~ref_clk_i;
  end
  initial begin
    lnk_clk = 1'b0;
    #2;
    forever #16 lnk_clk = ~lnk_clk;
  end

  dspmc_scan_port #(.BSR_LEN(BSR)) u_dspmc_scan_port (
    .ref_clk_i(ref_clk_i), .reset_i(reset_i), .tck_i(tck), .tms_i(tms), .tdi_i(tdi),
    .tdo_o(tdo), .tdo_oe_o(), .debug_logic_reset_n_i(dbg_rst_n),
    .debug_logic_reset_n_o(), .debug_logic_reset_n_oe_o(), .returned_scan_clock_o(),
    .scan_mode_select_pin_i(mode_pin), .factory_test_select_pin_i(1'b0),
    .test_mode_reserved_o(), .boundary_mode_o(bmode), .pin_sample_i(pins),
    .pin_drive_o(drive), .extest_active_o(ext), .core_capture_i(core_cap),
    .core_insn_o(core_insn), .core_insn_valid_o(), .core_in_debug_i(halted),
    .ice_capture_i(ice_cap), .ice_update_o(ice_upd), .ice_update_valid_o(),
    .comm_channel_tx_activity_i(tx_act), .comm_channel_rx_activity_i(rx_act),
    .comm_tx_irq_o(), .comm_rx_irq_o());

  dspmc_probe u_dspmc_probe (.lnk_clk_i(lnk_clk), .tdo_i(tdo), .tck_o(tck), .tms_o(tms),
                             .tdi_o(tdi));

  function automatic logic [63:0] lo(input logic [63:0] v, input int k);
    return v & ((64'h1 << k) - 64'h1);
  endfunction : lo

  task automatic chk(input logic [63:0] got, input logic [63:0] exp);
    num_checks++;
    if (got !== exp) begin
      bad_count++;
      $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : chk

  task automatic wrap_up();
    $display("checks=%0d mismatches=%0d", num_checks, bad_count);
    if (bad_count == 0 && num_checks > 0) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  endtask : wrap_up

  // Mode pin settles well before reset lets go
  task automatic chip_reset(input logic m);
    @(posedge ref_clk_i);
    mode_pin <= m;
    reset_i  <= 1'b1;
    repeat (4) @(posedge ref_clk_i);
    reset_i <= 1'b0;
    repeat (8) @(posedge ref_clk_i);
  endtask : chip_reset

  // Random channel activity in the background
  always @(posedge ref_clk_i) begin
    tx_act <= 1'($urandom);
    rx_act <= 1'($urandom);
  end

  // Generous ceiling against a hung handshake
  initial begin
    #400us;
    bad_count++;
    wrap_up();
  end

  // Main sequence
  initial begin
    reset_i = 1'b1;
    mode_pin = 1'b0;
    dbg_rst_n = 1'b1;
    halted = 1'b1;
    pins = '0;
    core_cap = '0;
    ice_cap = '0;
    bad_count = 0;
    num_checks = 0;
    din = 64'($urandom(6));
    chip_reset(1'b0);
    chk(64'(bmode), 64'h0);
    u_dspmc_probe.tap_reset();
    u_dspmc_probe.scan(1'b0, din, 32, dout);
    chk(lo(dout, 32), 64'(dspmc_pkg::ID_VALUE));
    u_dspmc_probe.scan(1'b1, 64'(dspmc_pkg::INS_BYPASS), 4, dout);
    chk(lo(dout, 4), 64'(dspmc_pkg::IR_CAPTURE));
    din = {$urandom, $urandom};
    u_dspmc_probe.scan(1'b0, din, 8, dout);
    chk(lo(dout, 8), lo({din[62:0], 1'b0}, 8));
    // Both internal chains, captured and updated
    for (int c = 0; c < 2; c++) begin
      n = (c == 0) ? 33 : 38;
      @(posedge ref_clk_i);
      core_cap <= 33'({$urandom, $urandom});
      ice_cap  <= 38'({$urandom, $urandom});
      u_dspmc_probe.scan(1'b1, 64'(dspmc_pkg::INS_SCAN_N), 4, dout);
      din = (c == 0) ? 64'(dspmc_pkg::CHAIN_CORE) : 64'(dspmc_pkg::CHAIN_ICE);
      u_dspmc_probe.scan(1'b0, din, 4, dout);
      u_dspmc_probe.scan(1'b1, 64'(dspmc_pkg::INS_INTEST), 4, dout);
      if (c == 0) begin
        // Running core: the update must insert nothing
        @(posedge ref_clk_i);
        halted <= 1'b0;
        u_dspmc_probe.scan(1'b0, 64'h0, n, dout);
        chk(64'(core_insn), 64'h0);
        @(posedge ref_clk_i);
        halted <= 1'b1;
      end
      din = {$urandom, $urandom};
      cap = (c == 0) ? 64'(core_cap) : 64'(ice_cap);
      u_dspmc_probe.scan(1'b0, din, n, dout);
      chk(lo(dout, n), cap);
      chk((c == 0) ? 64'(core_insn) : 64'(ice_upd), lo(din, n));
    end
    // Short debug reset pulse brings the instruction back to identify
    u_dspmc_probe.scan(1'b1, 64'(dspmc_pkg::INS_BYPASS), 4, dout);
    @(posedge ref_clk_i);
    dbg_rst_n <= 1'b0;
    repeat (3) @(posedge ref_clk_i);
    dbg_rst_n <= 1'b1;
    repeat (6) @(posedge ref_clk_i);
    u_dspmc_probe.idle(3);
    u_dspmc_probe.scan(1'b0, 64'h0, 32, dout);
    chk(lo(dout, 32), 64'(dspmc_pkg::ID_VALUE));
    // Boundary scan mode
    chip_reset(1'b1);
    chk(64'(bmode), 64'h1);
    u_dspmc_probe.tap_reset();
    @(posedge ref_clk_i);
    pins <= BSR'($urandom);
    u_dspmc_probe.scan(1'b1, 64'(dspmc_pkg::INS_SAMPLE), 4, dout);
    u_dspmc_probe.scan(1'b0, 64'h0, BSR, dout);
    chk(lo(dout, BSR), 64'(pins));
    u_dspmc_probe.scan(1'b1, 64'(dspmc_pkg::INS_EXTEST), 4, dout);
    din = {$urandom, $urandom};
    u_dspmc_probe.scan(1'b0, din, BSR, dout);
    chk(64'(drive), lo(din, BSR));
    chk(64'(ext), 64'h1);
    // Pin change without reset is ignored, reset takes it
    @(posedge ref_clk_i);
    mode_pin <= 1'b0;
    repeat (10) @(posedge ref_clk_i);
    chk(64'(bmode), 64'h1);
    chip_reset(1'b0);
    chk(64'(bmode), 64'h0);
    wrap_up();
  end
endmodule : test_debug_scan_port_mode_control
